/* shared/itc_pkg.sv */
// Constants shared by the target and trigger configuration block.
package itc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] ITC_TGT_BASE = 12'h800;
	localparam logic [11:0] ITC_TGT_SPAN = 12'h400;
	localparam logic [11:0] ITC_CFG_BASE = 12'hC00;
	localparam logic [11:0] ITC_CFG_SPAN = 12'h100;

	// ****************************************************************
	// Field layout and fixed values
	// ****************************************************************
	localparam int          ITC_MAX_CPU    = 8;
	localparam int          ITC_TGT_W      = 8;
	localparam int          ITC_TGT_PER_WD = 4;
	localparam int          ITC_CFG_PER_WD = 16;
	localparam int          ITC_BANKED_TGT = 8;
	localparam int          ITC_SGI_END    = 16;
	localparam int          ITC_PPI_END    = 32;
	localparam int          ITC_PPI_NUM    = 16;
	localparam logic [1:0]  ITC_SGI_CFG    = 2'h2;
	localparam logic [31:0] ITC_ZERO_WORD  = 32'h0000_0000;
	localparam logic [7:0]  ITC_TGT_RST    = 8'h00;

	typedef logic [ITC_TGT_W-1:0] itc_tgt_t;

endpackage

/* shared/itc_route_if.sv */
// Carrier between the register file and the routing stage.
`timescale 1ns/100ps

interface itc_route_if #(
	parameter int NUM_IRQ = 64
);
	import itc_pkg::*;

	itc_tgt_t [NUM_IRQ-1:0] tgt;
	logic     [NUM_IRQ-1:0] pend;
	logic     [NUM_IRQ-1:0] act;
	itc_tgt_t [NUM_IRQ-1:0] fwd;

	modport regs  (output tgt, output pend, output act, input fwd);
	modport route (input tgt, input pend, input act, output fwd);
endinterface

/* logic/itc_route.sv */
// Routing stage: applies target sets to pending interrupts.
`timescale 1ns/100ps

module itc_route
	import itc_pkg::*;
#(
	parameter int NUM_IRQ = 64
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Link to the register file
	itc_route_if.route rt
);

	// ****************************************************************
	// Effective targets and forwarded pending state
	// ****************************************************************
	itc_tgt_t [NUM_IRQ-1:0] eff_q;
	itc_tgt_t [NUM_IRQ-1:0] eff_d;
	itc_tgt_t [NUM_IRQ-1:0] fwd_q;
	itc_tgt_t [NUM_IRQ-1:0] fwd_d;

	// The stored set is copied one cycle late, so a write steers routing
	// only from the second edge after it is taken.
	always_comb begin
		for (int m = 0; m < NUM_IRQ; m++) begin
			// R8: hold while active and pending
			if (rt.act[m] && rt.pend[m]) begin
				eff_d[m] = eff_q[m];
			end else begin
				// R9: delayed routing update
				eff_d[m] = rt.tgt[m];
			end
			// R6: pend at added interfaces, R7: withdraw at removed ones
			// R22: an empty set forwards nothing
			fwd_d[m] = rt.pend[m] ? eff_q[m] : ITC_TGT_RST;
		end
	end

	// Registers only; activity is never touched here.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			eff_q <= '0;
			fwd_q <= '0;
		end else begin
			eff_q <= eff_d;
			fwd_q <= fwd_d;
		end
	end

	// R5: active state passes untouched
	assign rt.fwd = fwd_q;

endmodule

/* logic/itc_top.sv */
// Target routing and trigger configuration registers behind an APB port.
`timescale 1ns/100ps

// What this block does
// R1: Eight-bit target set per interrupt, bit k selects processor interface k.
// R2: Target words 0 to 7 read back the reading processor's own bit.
// R3: Target bits of absent interfaces read zero and drop writes.
// R4: Target of interrupt m sits at 0x800 plus 4*(m/4), lane m%4.
// R5: Target writes accepted anytime and never change activity.
// R6: Adding an interface makes a pending interrupt pend there.
// R7: Removing an interface withdraws pending at that interface.
// R8: Active-and-pending interrupts keep old routing until activity clears.
// R9: New targets steer routing two cycles after the write is taken.
// R10: Two-bit trigger field per supported interrupt.
// R11: Software-generated interrupt trigger fields are read-only.
// R12: Private peripheral upper trigger bit writability is a build parameter.
// R13: Trigger fields of absent interrupts read zero and ignore writes.
// R14: Non-secure access sees group 0 trigger fields as zero, writes dropped; software-generated fields still read as edge.
// R15: Lockdown freezes trigger fields of lockable group 0 shared interrupts.
// R16: Software disables an interrupt before changing its trigger field.
// R17: Writable private triggers are banked per processor in multiprocessor builds.
// R18: Upper trigger bit one means edge, zero level; lower bit reserved.
// R19: Software-generated interrupts read upper trigger bit as one, writes dropped.
// R20: Trigger of interrupt m sits at 0xC00 plus 4*(m/16), field m%16.
// R21: Single-processor build reads all target fields as zero, writes ignored.
// R22: Shared interrupts with empty target sets reach no processor.
module itc_top
	import itc_pkg::*;
#(
	parameter int          NUM_IRQ    = 64,
	parameter int          NUM_CPU    = 2,
	parameter bit          PPI_CFG_WR = 1'b1,
	parameter logic [15:0] PPI_EDGE_RST = 16'h0000,
	parameter bit          SECURITY   = 1'b1,
	parameter bit          LOCKDOWN   = 1'b1,
	parameter int          LOCK_SPIS  = 32
)(
	// Clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              rst,
	// APB slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [11:0]                       paddr,
	input  wire logic [31:0]                       pwdata,
	input  wire logic [3:0]                        pstrb,
	input  wire logic [2:0]                        pprot,
	input  wire logic [2:0]                        acc_cpu,
	output logic      [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// Distributor state
	input  wire logic [NUM_IRQ-1:0]                irq_pending,
	input  wire logic [NUM_IRQ-1:0]                irq_active,
	input  wire logic [NUM_IRQ-1:0]                irq_group1,
	input  wire logic                              cfg_lockdown,
	// Processor side
	output logic      [NUM_CPU-1:0][NUM_IRQ-1:0]   cpu_pend,
	output logic      [NUM_IRQ-1:0]                irq_edge,
	output logic      [NUM_CPU-1:0][ITC_PPI_NUM-1:0] ppi_edge
);

	// ****************************************************************
	// Access decode
	// ****************************************************************
	localparam itc_tgt_t CPU_MASK = itc_tgt_t'((1 << NUM_CPU) - 1);

	logic        ns_acc;
	logic        tgt_hit;
	logic        cfg_hit;
	logic [11:0] tgt_off;
	logic [11:0] cfg_off;
	logic [9:0]  wd_idx;
	logic        wr_take;
	logic [2:0]  bank;

	// Non-secure when the APB protection bit says so.
	assign ns_acc  = pprot[1];
	assign tgt_off = paddr - ITC_TGT_BASE;
	assign cfg_off = paddr - ITC_CFG_BASE;
	// R4: target word index
	assign tgt_hit = (paddr >= ITC_TGT_BASE) && (tgt_off < ITC_TGT_SPAN);
	// R20: trigger word index
	assign cfg_hit = (paddr >= ITC_CFG_BASE) && (cfg_off < ITC_CFG_SPAN);
	assign wd_idx  = tgt_hit ? tgt_off[11:2] : cfg_off[11:2];
	assign wr_take = psel && penable && pwrite;
	// R17: banking only where more than one processor exists
	assign bank    = (NUM_CPU > 1) ? acc_cpu : 3'h0;

	// Fields that a non-secure access must not see.
	function automatic logic ns_hidden(input int m, input logic ns);
		// R14: group 0 hidden from non-secure
		return SECURITY && ns && !irq_group1[m];
	endfunction

	// Fields frozen by configuration lockdown.
	function automatic logic locked(input int m);
		// R15: lockable group 0 shared interrupts
		return LOCKDOWN && cfg_lockdown && !irq_group1[m]
			&& (m >= ITC_PPI_END) && (m < ITC_PPI_END + LOCK_SPIS);
	endfunction

	// ****************************************************************
	// Stored fields
	// ****************************************************************
	itc_tgt_t [NUM_IRQ-1:0]                tgt_q;
	itc_tgt_t [NUM_IRQ-1:0]                tgt_d;
	logic     [NUM_IRQ-1:0]                edge_q;
	logic     [NUM_IRQ-1:0]                edge_d;
	logic     [NUM_CPU-1:0][ITC_PPI_NUM-1:0] ppi_q;
	logic     [NUM_CPU-1:0][ITC_PPI_NUM-1:0] ppi_d;

	// Write side of both register groups.
	always_comb begin
		int lane;
		int fld;
		lane   = 0;
		fld    = 0;
		tgt_d  = tgt_q;
		edge_d = edge_q;
		ppi_d  = ppi_q;
		for (int m = ITC_PPI_END; m < NUM_IRQ; m++) begin
			lane = m % ITC_TGT_PER_WD;
			// R5: writes accepted at any time
			// R21: single-processor build ignores target writes
			if (wr_take && tgt_hit && (NUM_CPU > 1) && pstrb[lane]
				&& (int'(wd_idx) == m / ITC_TGT_PER_WD)
				&& !ns_hidden(m, ns_acc) && !locked(m)) begin
				// R3: absent interface bits dropped
				tgt_d[m] = pwdata[lane*8 +: 8] & CPU_MASK;
			end
		end
		for (int m = ITC_SGI_END; m < NUM_IRQ; m++) begin
			fld  = m % ITC_CFG_PER_WD;
			// R11: first word never written
			// R13: absent interrupts fall outside the loop
			if (wr_take && cfg_hit && pstrb[fld / 4]
				&& (int'(wd_idx) == m / ITC_CFG_PER_WD)
				&& !ns_hidden(m, ns_acc) && !locked(m)) begin
				if (m >= ITC_PPI_END) begin
					// R18: upper bit only, lower bit reserved
					edge_d[m] = pwdata[2*fld + 1];
				end else if (PPI_CFG_WR) begin
					// R12: private bit writable by build choice
					// R17: per-processor bank
					ppi_d[bank][fld] = pwdata[2*fld + 1];
				end
			end
		end
	end

	// Field registers. Targets reset empty, so nothing routes until set.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tgt_q  <= '0;
			edge_q <= '0;
			for (int c = 0; c < NUM_CPU; c++) begin
				ppi_q[c] <= PPI_EDGE_RST;
			end
		end else begin
			tgt_q  <= tgt_d;
			edge_q <= edge_d;
			ppi_q  <= ppi_d;
		end
	end

	// ****************************************************************
	// Read side
	// ****************************************************************
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic        err_d;
	logic        err_q;

	// Read data is formed in the setup cycle and held for the access.
	always_comb begin
		int m;
		m       = 0;
		rdata_d = rdata_q;
		err_d   = err_q;
		if (psel && !penable) begin
			rdata_d = ITC_ZERO_WORD;
			err_d   = !(tgt_hit || cfg_hit);
			if (tgt_hit && (NUM_CPU > 1)) begin
				for (int k = 0; k < ITC_TGT_PER_WD; k++) begin
					m = int'(wd_idx) * ITC_TGT_PER_WD + k;
					if (int'(wd_idx) < ITC_BANKED_TGT) begin
						// R2: reader's own interface bit
						rdata_d[k*8 +: 8] = itc_tgt_t'(1 << acc_cpu) & CPU_MASK;
					end else if (m < NUM_IRQ && !ns_hidden(m, ns_acc)) begin
						// R1: stored target set
						rdata_d[k*8 +: 8] = tgt_q[m];
					end
				end
			end
			if (cfg_hit) begin
				for (int f = 0; f < ITC_CFG_PER_WD; f++) begin
					m = int'(wd_idx) * ITC_CFG_PER_WD + f;
					if (m < ITC_SGI_END) begin
						// R19: software interrupts always edge
						rdata_d[2*f +: 2] = ITC_SGI_CFG;
					end else if (m < NUM_IRQ && !ns_hidden(m, ns_acc)) begin
						// R10: two-bit field
						rdata_d[2*f + 1] = (m < ITC_PPI_END)
							? ppi_q[bank][m - ITC_SGI_END] : edge_q[m];
					end
				end
			end
		end
	end

	// Read data and error registers.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rdata_q <= ITC_ZERO_WORD;
			err_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	// Zero wait states: every access completes in its first access cycle.
	assign pready  = 1'b1;
	assign prdata  = rdata_q;
	assign pslverr = err_q && psel && penable;

	// ****************************************************************
	// Routing stage
	// ****************************************************************
	itc_route_if #(.NUM_IRQ(NUM_IRQ)) rt_if ();

	assign rt_if.tgt  = tgt_q;
	assign rt_if.pend = irq_pending;
	assign rt_if.act  = irq_active;

	itc_route #(
		.NUM_IRQ (NUM_IRQ)
	) u_route (
		.clk_sys (clk_sys),
		.rst     (rst),
		.rt      (rt_if)
	);

	// Transpose forwarded state into one vector per processor.
	for (genvar c = 0; c < NUM_CPU; c++) begin : g_cpu
		for (genvar m = 0; m < NUM_IRQ; m++) begin : g_irq
			assign cpu_pend[c][m] = rt_if.fwd[m][c];
		end
		assign ppi_edge[c] = ppi_q[c];
	end

	// Trigger type per interrupt; private entries follow processor 0's bank.
	for (genvar m = 0; m < NUM_IRQ; m++) begin : g_edge
		if (m < ITC_SGI_END) begin : g_sgi
			// R19: software interrupts are edge
			assign irq_edge[m] = ITC_SGI_CFG[1];
		end else if (m < ITC_PPI_END) begin : g_ppi
			assign irq_edge[m] = ppi_q[0][m - ITC_SGI_END];
		end else begin : g_spi
			assign irq_edge[m] = edge_q[m];
		end
	end

endmodule

/* testbench/itc_top_assertions.sv */
// Port-level checks for the target and trigger configuration block.
`timescale 1ns/100ps
module itc_top_assertions
	import itc_pkg::*;
#(
	parameter int NUM_IRQ = 64,
	parameter int NUM_CPU = 2
)(
	// Clock and reset
	input logic                            clk_sys,
	input logic                            rst,
	// APB side
	input logic                            psel,
	input logic                            penable,
	input logic                            pwrite,
	input logic [11:0]                     paddr,
	input logic [2:0]                      acc_cpu,
	input logic [31:0]                     prdata,
	input logic                            pslverr,
	// Routing side
	input logic [NUM_IRQ-1:0]              irq_pending,
	input logic [NUM_CPU-1:0][NUM_IRQ-1:0] cpu_pend,
	input logic [NUM_IRQ-1:0]              irq_edge
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic             rd_acc;
	logic [NUM_IRQ-1:0] any_pend;
	// Merge all interfaces so one check covers every processor.
	always_comb begin
		any_pend = '0;
		for (int c = 0; c < NUM_CPU; c++) any_pend = any_pend | cpu_pend[c];
	end
	assign rd_acc = psel && penable && !pwrite;
	AST_UNMAPPED: assert property (rd_acc && paddr < ITC_TGT_BASE |-> pslverr && prdata == 0)
		else $error("unmapped read not refused");
	AST_MAPPED: assert property (psel && penable && paddr >= 12'h800 && paddr < 12'hD00 |-> !pslverr)
		else $error("mapped access refused");
	AST_OWN_CPU: assert property (rd_acc && paddr[11:5] == 7'h40 && acc_cpu < NUM_CPU && NUM_CPU > 1
		|-> prdata == {4{8'(1 << acc_cpu)}}) else $error("banked target wrong");
	AST_ABSENT_CPU: assert property (rd_acc && paddr[11:10] == 2'b10
		|-> (prdata & {4{~8'((1 << NUM_CPU) - 1)}}) == 0) else $error("absent cpu bit set");
	AST_SGI_WORD: assert property (rd_acc && paddr == ITC_CFG_BASE |-> prdata == 32'hAAAA_AAAA)
		else $error("sgi trigger word wrong");
	AST_LOW_RSVD: assert property (rd_acc && paddr[11:8] == 4'hC |-> (prdata & 32'h5555_5555) == 0)
		else $error("reserved trigger bit set");
	AST_SGI_EDGE: assert property (irq_edge[15:0] == 16'hFFFF) else $error("sgi not edge");
	AST_PEND_CAUSE: assert property (1 |=> (any_pend & ~$past(irq_pending)) == 0)
		else $error("forward without pending");
	AST_EDGE_HOLD: assert property (!(psel && penable && pwrite) |=> $stable(irq_edge))
		else $error("trigger changed without write");
	// Main scenarios reached.
	cover property (rd_acc && pslverr);
	cover property (|any_pend);
	cover property (rd_acc && paddr == ITC_CFG_BASE);
endmodule

bind itc_top itc_top_assertions #(.NUM_IRQ(NUM_IRQ), .NUM_CPU(NUM_CPU)) i_itc_top_assertions (.*);

/* testbench/itc_cpu_model.sv */
// Processor interface model that records interrupts offered to it.
`timescale 1ns/100ps
module itc_cpu_model #(
	parameter int NUM_CPU = 2,
	parameter int NUM_IRQ = 64
)(
	// Clock and reset
	input logic                            clk_sys,
	input logic                            rst,
	// Forwarded interrupts and what each interface has seen
	input logic [NUM_CPU-1:0][NUM_IRQ-1:0] cpu_pend,
	output logic [NUM_CPU-1:0]             seen_q
);
	logic [NUM_CPU-1:0] seen_d;
	always_comb begin
		for (int c = 0; c < NUM_CPU; c++) seen_d[c] = seen_q[c] | (|cpu_pend[c]);
	end
	// Sticky, so a short forward is not missed between bench checks.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) seen_q <= '0;
		else seen_q <= seen_d;
	end
endmodule

/* testbench/itc_top_tb.sv */
// Self-checking bench for the target and trigger configuration block.
`timescale 1ns/100ps
module itc_top_tb;
	import itc_pkg::*;
	localparam int          NI = 64;
	localparam int          NC = 2;
	localparam logic [31:0] TM = {4{8'((1 << NC) - 1)}};
	localparam logic [31:0] CM = 32'hAAAA_AAAA;
	logic                  clk_sys, rst, psel, penable, pwrite, pslverr, pready, cfg_lockdown, er;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, rd, lf;
	logic [3:0]            pstrb;
	logic [2:0]            pprot, acc_cpu;
	logic [NI-1:0]         irq_pending, irq_active, irq_group1, irq_edge;
	logic [NC-1:0][NI-1:0] cpu_pend;
	logic [NC-1:0][15:0]   ppi_edge;
	logic [NC-1:0]         seen_q;
	int                    err_total, comparisons;
	itc_top #(.NUM_IRQ(NI), .NUM_CPU(NC)) i_itc_top (.*);
	itc_cpu_model #(.NUM_CPU(NC), .NUM_IRQ(NI)) i_itc_cpu_model (.*);
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] edges(input logic [31:0] d);
		for (int f = 0; f < 16; f++) edges[f] = d[2*f+1];
	endfunction
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask
	// Optional target write for interrupt 36, then the routing is sampled once settled.
	task automatic rt(input logic w, input logic [7:0] t, input logic [1:0] exp);
		if (w) apb(1'b1, 12'h824, {24'h00_0000, t});
		repeat (w ? 2 : 3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk({cpu_pend[1][36], cpu_pend[0][36]}, exp);
		@(posedge clk_sys);
	endtask
	task automatic test_done;
		if (err_total == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		test_done();
	end
	initial begin
		{psel, penable, pwrite, cfg_lockdown, paddr, pwdata, pprot, acc_cpu} = '0;
		{irq_pending, irq_active, err_total, comparisons} = '0;
		irq_group1 = '1;
		pstrb = 4'hF;
		lf = 32'h0000_02bf;
		rst = 1'b1;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rchk(12'h820, 32'h0000_0000);
		rchk(ITC_CFG_BASE, CM);
		rchk(12'hC04, 32'h0000_0000);
		// interrupts idle while trigger fields change
		for (int i = 0; i < 8; i++) begin
			lf = nxt(lf);
			apb(1'b1, 12'h820 + 12'(4 * i), lf);
			rchk(12'h820 + 12'(4 * i), lf & TM);
			apb(1'b1, 12'hC08 + 12'(4 * (i % 2)), lf);
			rchk(12'hC08 + 12'(4 * (i % 2)), lf & CM);
			chk(irq_edge[32 + 16 * (i % 2) +: 16], edges(lf));
		end
		apb(1'b1, 12'h840, 32'hFFFF_FFFF);
		rchk(12'h840, 32'h0000_0000);
		apb(1'b1, 12'hC10, 32'hFFFF_FFFF);
		rchk(12'hC10, 32'h0000_0000);
		for (int c = 0; c < NC; c++) begin
			acc_cpu <= 3'(c);
			apb(1'b1, 12'h804, 32'h0000_0000);
			rchk(12'h804, {4{8'(1 << c)}});
		end
		lf = nxt(lf);
		apb(1'b1, 12'hC04, lf);
		rchk(12'hC04, lf & CM);
		chk(ppi_edge[1], edges(lf));
		chk(ppi_edge[0], 16'h0000);
		chk(irq_edge[31:16], 16'h0000);
		acc_cpu <= 3'd0;
		apb(1'b1, ITC_CFG_BASE, 32'hFFFF_FFFF);
		rchk(ITC_CFG_BASE, CM);
		apb(1'b0, 12'h400, 32'h0000_0000);
		chk({er, rd}, {1'b1, 32'h0000_0000});
		irq_group1[33] <= 1'b0;
		apb(1'b1, 12'hC08, 32'hFFFF_FFFF);
		pprot <= 3'b010;
		apb(1'b1, 12'hC08, 32'h0000_0000);
		rchk(12'hC08, 32'h0000_0000);
		pprot <= 3'b000;
		rchk(12'hC08, 32'h0000_0008);
		cfg_lockdown <= 1'b1;
		apb(1'b1, 12'hC08, 32'h0000_0000);
		rchk(12'hC08, 32'h0000_0008);
		cfg_lockdown <= 1'b0;
		pstrb <= 4'h1;
		irq_pending[36] <= 1'b1;
		rt(1'b1, 8'h02, 2'b10);
		rt(1'b1, 8'h01, 2'b01);
		irq_active[36] <= 1'b1;
		rt(1'b1, 8'h02, 2'b01);
		irq_active[36] <= 1'b0;
		rt(1'b0, 8'h00, 2'b10);
		rt(1'b1, 8'h00, 2'b00);
		chk(seen_q, 2'b11);
		test_done();
	end
endmodule
